// ==== core/sarc_cfg.svh ====
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SARC_CSR_ADDR 8'h34
`define SARC_RHI_ADDR 8'h35
`define SARC_RLO_ADDR 8'h36

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SARC_DONE_BIT  7
`define SARC_SPEED_BIT 6
`define SARC_PWR_BIT   5
`define SARC_TRIM_BIT  4
`define SARC_SLOW_BIT  3
`define SARC_GAIN_BIT  2

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define SARC_CSR_RST  8'h00
`define SARC_RLO_RST  8'h00
`define SARC_RES_RST  10'h000
`define SARC_CHAN_MAX 3'h6
`define SARC_RES_MSB  10'h200

// ------------------------------------------------------------
// timing counts, in core_clk cycles or converter ticks
// ------------------------------------------------------------
`define SARC_SAMPLE_TICKS 3'h4
`define SARC_BIT_TICKS    2'h3
`define SARC_STAB_CYCLES  6'h20

`endif

// ==== core/sarc_pkg.sv ====
package sarc_pkg;

    // converter sequencing states, one-hot
    typedef enum logic [3:0] {
        SARC_IDLE   = 4'h1,
        SARC_STAB   = 4'h2,
        SARC_SAMPLE = 4'h4,
        SARC_CONV   = 4'h8
    } sarc_state_type;

    // register port request from the cpu side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sarc_bus_type;

    // controls toward the analog front end
    typedef struct packed {
        logic       conv_power;
        logic       amp_power;
        logic       amp_insert;
        logic       amp_zero;
        logic       route_en;
        logic [2:0] channel;
        logic       sample;
    } sarc_ana_type;

endpackage : sarc_pkg

// ==== core/sarc_sar_step.sv ====
`timescale 1ns/10ps
`include "sarc_cfg.svh"

module sarc_sar_step
    import sarc_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_core_n,
    // sequencing
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       step,
    input  wire logic       cmp_hi,
    // results
    output logic [9:0]      trial_r,
    output logic [9:0]      result_r,
    output logic            done_r
);

    logic [9:0] mask_r;
    logic [9:0] keep;

    // keep the trial bit when the input sits above the trial level
    assign keep = cmp_hi ? (trial_r) : (trial_r & ~mask_r);

    // ------------------------------------------------------------
    // binary search, msb first
    // ------------------------------------------------------------
    // monotonic by construction: each kept bit only raises the code
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            mask_r  <= 10'h000;
            trial_r <= 10'h000;
        end else if (abort) begin
            mask_r  <= 10'h000;
        end else if (start) begin
            mask_r  <= `SARC_RES_MSB;
            trial_r <= `SARC_RES_MSB;
        end else if (step && (mask_r != 10'h000)) begin
            mask_r  <= mask_r >> 1;
            trial_r <= keep | (mask_r >> 1);
        end
    end

    // above the top: all ones; below the bottom: zero
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            done_r   <= 1'b0;
            result_r <= `SARC_RES_RST;
        end else begin
            done_r <= 1'b0;
            if (!abort && step && mask_r[0]) begin
                done_r   <= 1'b1;
                result_r <= keep;
            end
        end
    end

    default clocking sar_cb @(posedge core_clk); endclocking
    default disable iff (!rst_core_n);

    trial_rise_a : assert property (
        step && cmp_hi && !abort && !start && (mask_r > 10'h001)
        |=> trial_r > $past(trial_r)
    ) else $error("trial code fell on a high comparison");

endmodule : sarc_sar_step

// ==== core/sarc_top.sv ====
// Behaviour
// - power-on bit set starts continuous conversion of the selected channel
// - each finished conversion loads both result registers and sets done
// - reading result high or writing control/status clears done
// - channel change aborts conversion, clears done, restarts on new input
// - channel code n routes analog input n, codes zero to six
// - result bits 9:2 in high register, bits 1:0 in low register
// - input above high reference gives all ones, no overflow flag
// - input below low reference gives zero in both registers
// - converter clock: cpu/2, cpu when speed, cpu/4 when slow
// - power-on bit switches converter and amplifier on and off together
// - gain select inserts the x8 amplifier in the input path
// - offset trim ties the amplifier input to 0 V
// - low register bits 7:5 read zero; software keeps csr 4:3 clear
// - wait leaves converter alone; halt disables it, then stabilise
// - control/status resets to zero
// - gain select needs no extra amplifier start-up delay
// - conversion codes are monotonic with the input
`timescale 1ns/10ps
`include "sarc_cfg.svh"

module sarc_top
    import sarc_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // register port
    input  wire sarc_bus_type bus_req,
    output logic [7:0]        rd_data,
    // power management
    input  wire logic         halt_req,
    // analog front end
    input  wire logic         cmp_above,
    output sarc_ana_type      ana_ctrl,
    output logic [9:0]        dac_code
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_core_n;
    // assert at once, release two edges later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_core_n <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    logic cmp_s1_r;
    logic cmp_s2_r;
    // the comparator is asynchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_above;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit
    logic wr_csr;
    logic wr_rlo;
    logic rd_rhi;
    assign wr_csr = bus_req.wr && hit(bus_req.addr, `SARC_CSR_ADDR);
    assign wr_rlo = bus_req.wr && hit(bus_req.addr, `SARC_RLO_ADDR);
    assign rd_rhi = bus_req.rd && hit(bus_req.addr, `SARC_RHI_ADDR);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic       speed_r;
    logic       pwr_on_r;
    logic [2:0] chan_r;
    logic       trim_r;
    logic       slow_r;
    logic       gain_r;
    // csr writes; bits 4:3 are not stored and read as zero
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            speed_r  <= 1'(`SARC_CSR_RST >> `SARC_SPEED_BIT);
            pwr_on_r <= 1'(`SARC_CSR_RST >> `SARC_PWR_BIT);
            chan_r   <= 3'(`SARC_CSR_RST);
        end else if (wr_csr) begin
            speed_r  <= bus_req.wdata[`SARC_SPEED_BIT];
            pwr_on_r <= bus_req.wdata[`SARC_PWR_BIT];
            chan_r   <= bus_req.wdata[2:0];
        end
    end
    // low register control bits; result bits there are read only
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            trim_r <= 1'b0;
            slow_r <= 1'b0;
            gain_r <= 1'b0;
        end else if (wr_rlo) begin
            trim_r <= bus_req.wdata[`SARC_TRIM_BIT];
            slow_r <= bus_req.wdata[`SARC_SLOW_BIT];
            gain_r <= bus_req.wdata[`SARC_GAIN_BIT];
        end
    end

    // ------------------------------------------------------------
    // converter clock divider
    // ------------------------------------------------------------
    logic [1:0] div_r;
    logic       adc_tick;
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    // free-running divider: a setting change takes effect within 4 cycles
    assign adc_tick = slow_r  ? (div_r == 2'h3) :
                      speed_r ? 1'b1 : div_r[0];

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    sarc_state_type state_r;
    logic           active;
    logic           chan_chg;
    logic           running;
    logic [5:0]     stab_r;
    logic [2:0]     smp_r;
    logic [1:0]     bit_r;
    logic           sar_start;
    logic           sar_step;
    logic           sar_abort;
    logic           sar_done;
    logic [9:0]     sar_result;
    // wait mode has no port here: only halt and the power-on bit gate the converter
    assign active  = pwr_on_r && !halt_req;
    assign running = (state_r == SARC_SAMPLE) || (state_r == SARC_CONV);
    // a new code in the channel field restarts the conversion
    assign chan_chg = wr_csr && (bus_req.wdata[2:0] != chan_r);
    assign sar_start = (state_r == SARC_SAMPLE) && adc_tick &&
                       (smp_r == `SARC_SAMPLE_TICKS - 3'h1) && !chan_chg;
    assign sar_step  = (state_r == SARC_CONV) && adc_tick &&
                       (bit_r == `SARC_BIT_TICKS - 2'h1);
    assign sar_abort = !active || chan_chg;
    // state register
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_r <= SARC_IDLE;
        end else begin
            case (state_r)
                SARC_IDLE: begin
                    if (active) begin
                        state_r <= SARC_STAB;
                    end
                end
                SARC_STAB: begin
                    if (!active) begin
                        state_r <= SARC_IDLE;
                    end else if (stab_r == `SARC_STAB_CYCLES) begin
                        state_r <= SARC_SAMPLE;
                    end
                end
                SARC_SAMPLE: begin
                    if (!active) begin
                        state_r <= SARC_IDLE;
                    end else if (sar_start) begin
                        state_r <= SARC_CONV;
                    end
                end
                SARC_CONV: begin
                    if (!active) begin
                        state_r <= SARC_IDLE;
                    end else if (chan_chg || sar_done) begin
                        state_r <= SARC_SAMPLE;
                    end
                end
                default: begin
                    state_r <= SARC_IDLE;
                end
            endcase
        end
    end

    // stabilisation count after power-up or wake from halt
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stab_r <= 6'h00;
        end else if (state_r != SARC_STAB) begin
            stab_r <= 6'h00;
        end else if (stab_r != `SARC_STAB_CYCLES) begin
            stab_r <= stab_r + 6'h01;
        end
    end

    // sample window and per-bit settle counts, in converter ticks
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            smp_r <= 3'h0;
        end else if ((state_r != SARC_SAMPLE) || chan_chg) begin
            smp_r <= 3'h0;
        end else if (adc_tick) begin
            smp_r <= smp_r + 3'h1;
        end
    end

    // three ticks cover the dac output flop and the two sync stages
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            bit_r <= 2'h0;
        end else if ((state_r != SARC_CONV) || sar_step) begin
            bit_r <= 2'h0;
        end else if (adc_tick) begin
            bit_r <= bit_r + 2'h1;
        end
    end

    sarc_sar_step u_sar (
        .core_clk   (core_clk),
        .rst_core_n (rst_core_n),
        .start      (sar_start),
        .abort      (sar_abort),
        .step       (sar_step),
        .cmp_hi     (cmp_s2_r),
        .trial_r    (dac_code),
        .result_r   (sar_result),
        .done_r     (sar_done)
    );

    // ------------------------------------------------------------
    // result and done flag
    // ------------------------------------------------------------
    logic [9:0] result_r;
    logic       done_r;
    // one load for both halves; nothing holds them between a low read and a high read
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            result_r <= `SARC_RES_RST;
        end else if (sar_done) begin
            result_r <= sar_result;
        end
    end
    // a completion in the clearing cycle wins, so no result is missed
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            done_r <= 1'b0;
        end else if (sar_done) begin
            done_r <= 1'b1;
        end else if (rd_rhi || wr_csr) begin
            done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            rd_data <= 8'h00;
        end else if (!bus_req.rd) begin
            rd_data <= 8'h00;
        end else begin
            case (bus_req.addr)
                `SARC_CSR_ADDR: begin
                    rd_data <= {done_r, speed_r, pwr_on_r, 2'b00, chan_r};
                end
                `SARC_RHI_ADDR: begin
                    rd_data <= result_r[9:2];
                end
                `SARC_RLO_ADDR: begin
                    rd_data <= {3'b000, trim_r, slow_r, gain_r,
                                result_r[1:0]};
                end
                default: begin
                    rd_data <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog front-end controls
    // ------------------------------------------------------------
    // gain change never restarts anything: the amp is already up
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ana_ctrl <= '0;
        end else begin
            ana_ctrl.conv_power <= active;
            ana_ctrl.amp_power  <= active;
            ana_ctrl.amp_insert <= gain_r;
            ana_ctrl.amp_zero   <= trim_r;
            ana_ctrl.route_en   <= active && (chan_r <= `SARC_CHAN_MAX);
            ana_ctrl.channel    <= chan_r;
            ana_ctrl.sample     <= (state_r == SARC_SAMPLE);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking top_cb @(posedge core_clk); endclocking
    default disable iff (!rst_core_n);

    sequence slow_run4;
        adc_tick && slow_r ##1 slow_r [*4];
    endsequence
    sequence csr_clear;
        (rd_rhi || wr_csr) && !sar_done;
    endsequence
    done_set_a : assert property (
        sar_done |=> done_r && (result_r == $past(sar_result))
    ) else $error("done or result not loaded on completion");
    done_clear_a : assert property (
        csr_clear |=> !done_r
    ) else $error("done survived a clearing access");
    chan_restart_a : assert property (
        chan_chg && running && active |=> state_r == SARC_SAMPLE
                                         ##1 smp_r <= 3'h1
    ) else $error("channel change did not restart sampling");
    route_follow_a : assert property (
        ##1 ana_ctrl.channel == $past(chan_r)
    ) else $error("mux select does not follow channel field");
    high_read_a : assert property (
        rd_rhi |=> rd_data == $past(result_r[9:2])
    ) else $error("high result read returned wrong bits");
    low_read_a : assert property (
        bus_req.rd && hit(bus_req.addr, `SARC_RLO_ADDR)
        |=> rd_data[7:5] == 3'b000 && rd_data[1:0] == $past(result_r[1:0])
    ) else $error("low register read wrong");
    slow_div_a : assert property (
        slow_run4 |-> adc_tick && !$past(adc_tick, 1)
                      && !$past(adc_tick, 2) && !$past(adc_tick, 3)
    ) else $error("slow converter clock not cpu over four");
    power_off_a : assert property (
        !active |=> state_r == SARC_IDLE && !ana_ctrl.conv_power
                    && !ana_ctrl.amp_power
    ) else $error("converter still on with power bit clear or halt");
    stab_wait_a : assert property (
        state_r == SARC_IDLE ##1 state_r == SARC_STAB
        |-> ##[1:40] (state_r != SARC_STAB)
    ) else $error("stabilisation wait did not end in time");
    csr_reset_a : assert property (
        $rose(rst_core_n) |-> !done_r && !pwr_on_r && !speed_r
                             && chan_r == 3'h0
    ) else $error("control/status not zero after reset");

endmodule : sarc_top

// ==== dv/sarc_src_model.sv ====
`timescale 1ns/10ps

module sarc_src_model
    import sarc_pkg::*;
(
    // clock
    input  wire logic         core_clk,
    // controls from the block
    input  wire sarc_ana_type ana_ctrl,
    input  wire logic [9:0]   dac_code,
    // comparator
    output logic              cmp_above
);
    // ------------------------------------------------------------
    // analog inputs
    // ------------------------------------------------------------
    // levels in half-code steps; odd values sit between two codes, so no tie
    int   level [0:6];
    int   held   = 0;
    logic wobble = 1'b0;

    // sample and hold: tracks while sampling, holds during the bit trials
    always @(posedge core_clk) begin
        wobble <= ~wobble;
        if (ana_ctrl.sample && ana_ctrl.route_en) begin
            if (ana_ctrl.amp_zero && ana_ctrl.amp_insert) begin
                held <= 0;
            end
            else begin
                held <= level[ana_ctrl.channel] * (ana_ctrl.amp_insert ? 8 : 1);
            end
        end
    end

    // unpowered or unrouted comparator output is noise, not a held level
    assign cmp_above = (ana_ctrl.conv_power && ana_ctrl.amp_power && ana_ctrl.route_en)
                     ? (2 * int'(dac_code) < held) : wobble;
endmodule : sarc_src_model

// ==== dv/sar_converter_control_bench.sv ====
`timescale 1ns/10ps
`include "sarc_cfg.svh"

module sar_converter_control_bench;
    import sarc_pkg::*;

    logic         core_clk;
    logic         rst_n;
    sarc_bus_type bus_req;
    logic [7:0]   rd_data;
    logic         halt_req;
    logic         cmp_above;
    sarc_ana_type ana_ctrl;
    logic [9:0]   dac_code;
    int           n_fail   = 0;
    int           compares = 0;
    // half-code input levels and the codes they must give
    int           lvl [7]  = '{683, -3, 5000, 1365, 3, 2045, 481};
    logic [9:0]   exp_r [7] = '{10'h155, 10'h000, 10'h3FF, 10'h2AA, 10'h001, 10'h3FE, 10'h0F0};

    sarc_top DUT (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .bus_req   (bus_req),
        .rd_data   (rd_data),
        .halt_req  (halt_req),
        .cmp_above (cmp_above),
        .ana_ctrl  (ana_ctrl),
        .dac_code  (dac_code)
    );

    sarc_src_model src (
        .core_clk  (core_clk),
        .ana_ctrl  (ana_ctrl),
        .dac_code  (dac_code),
        .cmp_above (cmp_above)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end
        else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // strobes drop at the next edge, so back-to-back calls leave one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b0, 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b0};
        #1 d = rd_data;
    endtask : rd

    task automatic wait_done(output logic ok);
        logic [7:0] v;
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            rd(`SARC_CSR_ADDR, v);
            ok = (v[7] === 1'b1);
        end
    endtask : wait_done

    // low first, then high: both halves come from one conversion
    task automatic res(output logic [9:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(`SARC_RLO_ADDR, lo);
        rd(`SARC_RHI_ADDR, hi);
        r = {hi, lo[1:0]};
    endtask : res

    // a conversion already in flight may carry old settings, so skip one
    task automatic conv_chk(input logic [2:0] ch, input logic [9:0] e);
        logic       ok;
        logic [7:0] v;
        logic [9:0] r;
        wr(`SARC_CSR_ADDR, {3'h3, 2'h0, ch});
        wait_done(ok);
        rd(`SARC_RHI_ADDR, v);
        wait_done(ok);
        chk("done", 1, ok);
        res(r);
        chk("result", e, r);
        rd(`SARC_CSR_ADDR, v);
        chk("done after high read", 0, v[7]);
    endtask : conv_chk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] v;
        chk("front end idle", 0, {ana_ctrl, dac_code});
        for (int a = 8'h34; a < 8'h38; a++) begin
            rd(a[7:0], v);
            chk("reset read", 0, v);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_chan();
        logic       ok;
        logic [7:0] v;
        for (int c = 0; c < 7; c++) begin
            conv_chk(c[2:0], exp_r[c]);
            chk("channel", c, ana_ctrl.channel);
            chk("powered", 2'h3, {ana_ctrl.conv_power, ana_ctrl.amp_power});
            chk("routed", 1, ana_ctrl.route_en);
        end
        wait_done(ok);
        wr(`SARC_CSR_ADDR, 8'h66);
        rd(`SARC_CSR_ADDR, v);
        chk("done after csr write", 8'h66, v);
        // code 7 names no input, so the mux must stay open
        wr(`SARC_CSR_ADDR, 8'h67);
        rd(`SARC_CSR_ADDR, v);
        chk("code 7 routing", 0, ana_ctrl.route_en);
        $display("test channels done");
    endtask : t_chan

    task automatic t_gain();
        logic [7:0] v;
        // gain only beside the slowest converter clock this core clock offers
        wr(`SARC_RLO_ADDR, 8'h0C);
        conv_chk(3'h4, 10'h00B);
        chk("amp inserted", 1, ana_ctrl.amp_insert);
        wr(`SARC_RLO_ADDR, 8'h1C);
        conv_chk(3'h4, 10'h000);
        chk("amp zeroed", 1, ana_ctrl.amp_zero);
        wr(`SARC_RLO_ADDR, 8'hEC);
        rd(`SARC_RLO_ADDR, v);
        chk("low control bits", 6'h03, v[7:2]);
        wr(`SARC_RLO_ADDR, 8'h00);
        $display("test gain done");
    endtask : t_gain

    // the interval between two bit trials is three converter ticks
    task automatic t_clock();
        logic [7:0] sp [3] = '{8'h63, 8'h23, 8'h63};
        logic [7:0] sl [3] = '{8'h00, 8'h00, 8'h08};
        int         dv [3] = '{1, 2, 4};
        logic [9:0] v;
        int         n;
        for (int k = 0; k < 3; k++) begin
            wr(`SARC_RLO_ADDR, sl[k]);
            wr(`SARC_CSR_ADDR, sp[k]);
            @(negedge ana_ctrl.sample);
            @(dac_code);
            @(dac_code);
            v = dac_code;
            n = 0;
            while (dac_code === v && n < 100) begin
                @(posedge core_clk);
                #1 n++;
            end
            chk("bit step cycles", 3 * dv[k], n);
        end
        $display("test clock done");
    endtask : t_clock

    task automatic t_switch();
        logic       ok;
        logic [7:0] v;
        logic [9:0] r;
        int         n;
        wr(`SARC_CSR_ADDR, 8'h62);
        @(negedge ana_ctrl.sample);
        repeat (8) @(posedge core_clk);
        wr(`SARC_CSR_ADDR, 8'h65);
        #1;
        // look 1 ns after each edge, once the registered output has settled
        for (n = 0; n < 4 && ana_ctrl.sample !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk("restart sampling", 1, ana_ctrl.sample);
        rd(`SARC_CSR_ADDR, v);
        chk("done cleared", 0, v[7]);
        wait_done(ok);
        res(r);
        chk("new channel result", exp_r[5], r);
        $display("test switch done");
    endtask : t_switch

    task automatic t_halt();
        logic       ok;
        logic [7:0] v;
        wr(`SARC_RLO_ADDR, 8'h00);
        wr(`SARC_CSR_ADDR, 8'h60);
        halt_req <= 1'b1;
        rd(`SARC_RHI_ADDR, v);
        chk("halt power", 0, {ana_ctrl.conv_power, ana_ctrl.amp_power});
        repeat (200) @(posedge core_clk);
        rd(`SARC_CSR_ADDR, v);
        chk("no done in halt", 0, v[7]);
        @(posedge core_clk);
        halt_req <= 1'b0;
        wait_done(ok);
        chk("done after wakeup", 1, ok);
        wr(`SARC_CSR_ADDR, 8'h40);
        rd(`SARC_CSR_ADDR, v);
        chk("power off", 0, {ana_ctrl.conv_power, ana_ctrl.amp_power});
        $display("test halt done");
    endtask : t_halt

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // the whole run needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        test_done();
    end

    initial begin
        bus_req  = '0;
        halt_req = 1'b0;
        rst_n    = 1'b0;
        foreach (lvl[i]) src.level[i] = lvl[i];
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_chan();
        t_gain();
        t_clock();
        t_switch();
        t_halt();
        test_done();
    end
endmodule : sar_converter_control_bench
